// ===== design/irq_poll_pkg.sv
// shared constants, masks and state codes for the interrupt poller
package irq_poll_pkg;

    typedef logic [7:0] byte_t;

    // input population
    localparam int INPUT_COUNT = 48;
    localparam int ENABLED_COUNT = 34;
    localparam int RESERVED_COUNT = 14;
    localparam int BYTE_COUNT = 6;
    localparam int SEL_W = 3;
    localparam int BYTE_W = 8;
    localparam int CPU_COUNT = 2;
    localparam int VEC_W = 4;
    localparam logic [SEL_W-1:0] FIRST_SEL = 3'h0;
    localparam logic [SEL_W-1:0] LAST_SEL = 3'h5;
    localparam logic [SEL_W-1:0] SEL_STEP = 3'h1;

    // bit positions of the per-cpu interrupt nibble
    localparam int VEC_ERR = 0;
    localparam int VEC_DEV = 1;
    localparam int VEC_RTC = 2;
    localparam int VEC_IPI = 3;

    // buffer settle time per poll step, least time so rounded up
    localparam int CLK_PERIOD_NS = 10;
    localparam int STEP_TIME_NS = 20;
    localparam int STEP_CYCLES =
        (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // which bit of which polled byte carries which source
    localparam byte_t ENABLE_MASK [BYTE_COUNT] =
        '{8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'h3F, 8'h00};
    localparam byte_t PCI_MASK [BYTE_COUNT] =
        '{8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'h00, 8'h00};
    localparam byte_t PCHIP_ERR_MASK [BYTE_COUNT] =
        '{8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h00};
    localparam byte_t HALT0_MASK [BYTE_COUNT] =
        '{8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h00};
    localparam byte_t HALT1_MASK [BYTE_COUNT] =
        '{8'h00, 8'h00, 8'h00, 8'h00, 8'h08, 8'h00};
    localparam byte_t ISA_MASK [BYTE_COUNT] =
        '{8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h00};
    localparam byte_t RTC_MASK [BYTE_COUNT] =
        '{8'h00, 8'h00, 8'h00, 8'h00, 8'h20, 8'h00};

    // poll sequencer states
    typedef enum logic [2:0] {
        ST_SELECT = 3'b000,
        ST_GRANT = 3'b001,
        ST_MERGE = 3'b010,
        ST_DRIVE = 3'b011,
        ST_STROBE = 3'b100
    } poll_state_e;

    // any enabled source of one class active in a polled byte
    function automatic logic hits(input byte_t mask, input byte_t data,
                                  input byte_t enable);
        hits = |(mask & data & enable);
    endfunction

endpackage

// ===== design/poll_pacer.sv
// divider that paces each poll step with a one-cycle tick
`timescale 1ns/1ps
`default_nettype none

module poll_pacer
#(
    parameter int STEPS = 2
)
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic run,
    output logic tick
);

    localparam int CNT_W = (STEPS > 1) ? $clog2(STEPS) : 1;
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(STEPS - 1);
    localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

    logic [CNT_W-1:0] count;

    ////////////////////////////////////////////////////////////////////////
    // count while running, restart from zero whenever stopped
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            count <= '0;
        end
        else if (!run || count == CNT_LAST)
        begin
            count <= '0;
        end
        else
        begin
            count <= count + CNT_ONE;
        end
    end

    // tick on the last cycle of each step
    always_comb
    begin
        tick = run && (count == CNT_LAST);
    end

endmodule

`default_nettype wire

// ===== design/irq_byte_store.sv
// small memory holding the latest polled interrupt bytes
`timescale 1ns/1ps
`default_nettype none

module irq_byte_store
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 6,
    parameter int ADDR_W = 3
)
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic wrEn,
    input wire logic [ADDR_W-1:0] wrAddr,
    input wire logic [WIDTH-1:0] wrData,
    input wire logic [ADDR_W-1:0] rdAddr,
    output logic [WIDTH-1:0] rdData
);

    logic [WIDTH-1:0] mem [DEPTH];

    ////////////////////////////////////////////////////////////////////////
    // write port
    always_ff @(posedge core_clk)
    begin
        if (wrEn)
        begin
            mem[wrAddr] <= wrData;
        end
    end

    // registered read port, one cycle latency
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            rdData <= '0;
        end
        else
        begin
            rdData <= mem[rdAddr];
        end
    end

endmodule

`default_nettype wire

// ===== design/irq_poller.sv
// general-purpose bus interrupt poller feeding two processors
//
// What this block does
// - poll forever, pause for other bus requests and at each round end for merge, drive and strobe
// - 48 inputs: 34 enabled, 14 reserved ignored
// - select byte code, assert byte output enable
// - after round drive vector, pulse vector strobe
// - device interrupt buffers selected by byte code
// - combine all pci interrupts, send out on bus
// - merge own and io-controller error interrupts
// - line 0 errors, 2 rtc, 3 ipi, 5 reserved
// - line 1 carries combined pci and isa
// - line 4 halt per cpu, jumper or software
// - nested isa levels arrive via one southbridge output
// - isa level assignment configurable inside southbridge
// - timer interrupt polled directly from square-wave output
// - addresses and data share the bus data lines
`timescale 1ns/1ps
`default_nettype none

module irq_poller
    import irq_poll_pkg::*;
#(
    parameter int STEPS = irq_poll_pkg::STEP_CYCLES
)
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic busRequest,
    output logic busGrant,
    output logic [irq_poll_pkg::SEL_W-1:0] byteSelect,
    output logic irqByteOutputEnable,
    output logic irqVectorStrobe,
    input wire logic [irq_poll_pkg::BYTE_W-1:0] busDataIn,
    output logic [irq_poll_pkg::BYTE_W-1:0] busDataOut,
    output logic busDataOe,
    input wire logic ctrlErrorIrq,
    input wire logic ioErrorIrq,
    input wire logic [irq_poll_pkg::CPU_COUNT-1:0] interprocessorIrq,
    input wire logic [irq_poll_pkg::CPU_COUNT-1:0] softwareHalt,
    output logic [irq_poll_pkg::CPU_COUNT-1:0] cpuHalt
);
    import irq_poll_pkg::*;

    poll_state_e state;
    poll_state_e next_state;
    logic [SEL_W-1:0] sel;
    logic [SEL_W-1:0] mergeIdx;
    logic [SEL_W-1:0] rdIdx;
    logic rdValid;
    logic mergeDone;
    logic pendingDrive;
    logic stepTick;
    logic [BYTE_W-1:0] rdData;
    logic accErr;
    logic accDev;
    logic accRtc;
    logic [CPU_COUNT-1:0] accHalt;
    logic [BYTE_W-1:0] next_vector;

    ////////////////////////////////////////////////////////////////////////
    // step pacing: full drive time with the enable up, also after reset
    poll_pacer #(
        .STEPS(STEPS)
    ) pacer (
        .core_clk(core_clk),
        .rst(rst),
        .run(state == ST_SELECT && irqByteOutputEnable),
        .tick(stepTick)
    );

    // polled bytes, written at the end of each step, read back to merge
    irq_byte_store #(
        .WIDTH(BYTE_W),
        .DEPTH(BYTE_COUNT),
        .ADDR_W(SEL_W)
    ) store (
        .core_clk(core_clk),
        .rst(rst),
        .wrEn(state == ST_SELECT && stepTick),
        .wrAddr(sel),
        .wrData(busDataIn),
        .rdAddr(mergeIdx),
        .rdData(rdData)
    );

    ////////////////////////////////////////////////////////////////////////
    // sequencer next state
    always_comb
    begin
        next_state = state;
        unique case (state)
            ST_SELECT:
            begin
                if (stepTick)
                begin
                    if (sel == LAST_SEL)
                        next_state = ST_MERGE;
                    else if (busRequest)
                        next_state = ST_GRANT;
                    else
                        next_state = ST_SELECT;
                end
            end
            ST_GRANT:
            begin
                if (!busRequest)
                    next_state = pendingDrive ? ST_DRIVE : ST_SELECT;
            end
            ST_MERGE:
            begin
                if (mergeDone)
                    next_state = busRequest ? ST_GRANT : ST_DRIVE;
            end
            ST_DRIVE:
            begin
                next_state = ST_STROBE;
            end
            ST_STROBE:
            begin
                next_state = ST_SELECT;
            end
            default:
            begin
                next_state = ST_SELECT;
            end
        endcase
    end

    // state register
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            state <= ST_SELECT;
        else
            state <= next_state;
    end

    ////////////////////////////////////////////////////////////////////////
    // byte select code: step through six codes, restart after strobe
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            sel <= FIRST_SEL;
        else if (state == ST_SELECT && stepTick && sel != LAST_SEL)
            sel <= sel + SEL_STEP;
        else if (state == ST_STROBE)
            sel <= FIRST_SEL;
    end

    // remember whether a grant interrupted the end of a round
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            pendingDrive <= 1'b0;
        else if (state == ST_MERGE && mergeDone)
            pendingDrive <= busRequest;
        else if (state == ST_DRIVE)
            pendingDrive <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // merge read-back: address, registered data, done flag
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            mergeIdx <= FIRST_SEL;
            rdIdx <= FIRST_SEL;
            rdValid <= 1'b0;
            mergeDone <= 1'b0;
        end
        else if (state == ST_MERGE)
        begin
            rdIdx <= mergeIdx;
            rdValid <= (mergeIdx <= LAST_SEL) && !mergeDone;
            if (mergeIdx <= LAST_SEL)
                mergeIdx <= mergeIdx + SEL_STEP;
            if (rdValid && rdIdx == LAST_SEL)
                mergeDone <= 1'b1;
        end
        else
        begin
            mergeIdx <= FIRST_SEL;
            rdIdx <= FIRST_SEL;
            rdValid <= 1'b0;
            mergeDone <= 1'b0;
        end
    end

    // source accumulators, cleared at round start, reserved bits masked
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            accErr <= 1'b0;
            accDev <= 1'b0;
            accRtc <= 1'b0;
            accHalt <= '0;
        end
        else if (state == ST_STROBE)
        begin
            accErr <= 1'b0;
            accDev <= 1'b0;
            accRtc <= 1'b0;
            accHalt <= '0;
        end
        else if (rdValid)
        begin
            // enable mask drops the reserved positions
            accErr <= accErr | hits(PCHIP_ERR_MASK[rdIdx], rdData,
                                    ENABLE_MASK[rdIdx]);
            accDev <= accDev
                | hits(PCI_MASK[rdIdx], rdData, ENABLE_MASK[rdIdx])
                | hits(ISA_MASK[rdIdx], rdData, ENABLE_MASK[rdIdx]);
            accRtc <= accRtc | hits(RTC_MASK[rdIdx], rdData,
                                    ENABLE_MASK[rdIdx]);
            accHalt[0] <= accHalt[0] | hits(HALT0_MASK[rdIdx], rdData,
                                            ENABLE_MASK[rdIdx]);
            accHalt[1] <= accHalt[1] | hits(HALT1_MASK[rdIdx], rdData,
                                            ENABLE_MASK[rdIdx]);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // per-cpu interrupt nibbles packed onto the byte
    always_comb
    begin
        next_vector = '0;
        for (int c = 0; c < CPU_COUNT; c++)
        begin
            next_vector[c*VEC_W + VEC_ERR] =
                accErr | ctrlErrorIrq | ioErrorIrq;
            next_vector[c*VEC_W + VEC_DEV] = accDev;
            next_vector[c*VEC_W + VEC_RTC] = accRtc;
            next_vector[c*VEC_W + VEC_IPI] = interprocessorIrq[c];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bus outputs decoded from the coming state
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            byteSelect <= FIRST_SEL;
            irqByteOutputEnable <= 1'b0;
            busGrant <= 1'b0;
            irqVectorStrobe <= 1'b0;
            busDataOe <= 1'b0;
        end
        else
        begin
            if (next_state == ST_SELECT)
                byteSelect <= (state == ST_SELECT && stepTick)
                    ? sel + SEL_STEP
                    : ((state == ST_STROBE) ? FIRST_SEL : sel);
            irqByteOutputEnable <= (next_state == ST_SELECT);
            busGrant <= (next_state == ST_GRANT);
            irqVectorStrobe <= (next_state == ST_STROBE);
            busDataOe <= (next_state == ST_DRIVE)
                || (next_state == ST_STROBE);
        end
    end

    // vector data held on the bus through drive and strobe
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            busDataOut <= '0;
        else if (next_state == ST_DRIVE && state != ST_DRIVE)
            busDataOut <= next_vector;
    end

    // halt lines, updated with each strobe
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            cpuHalt <= '0;
        else if (next_state == ST_STROBE)
            cpuHalt <= accHalt | softwareHalt;
    end

endmodule

`default_nettype wire

// ===== dv/irq_poller_chk.sv
// port assertions for the interrupt poller
`timescale 1ns/1ps
`default_nettype none

module irq_poller_chk
    import irq_poll_pkg::*;
#(
    parameter int STEPS = 2
)
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic busRequest,
    input wire logic busGrant,
    input wire logic [irq_poll_pkg::SEL_W-1:0] byteSelect,
    input wire logic irqByteOutputEnable,
    input wire logic irqVectorStrobe,
    input wire logic busDataOe
);
    import irq_poll_pkg::*;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////
    // vector strobe and poll sequencing
    AST_STROBE_IN_DRIVE: assert property (
        irqVectorStrobe |-> busDataOe && $past(busDataOe))
        else $error("strobe outside vector drive");
    AST_STROBE_PULSE: assert property (
        irqVectorStrobe |=> !irqVectorStrobe)
        else $error("strobe longer than one cycle");
    AST_SEL_RANGE: assert property (
        irqByteOutputEnable |-> byteSelect <= LAST_SEL)
        else $error("byte select beyond last byte");
    AST_STEP_HOLD: assert property (
        $rose(irqByteOutputEnable)
        |=> irqByteOutputEnable && $stable(byteSelect))
        else $error("poll step shorter than two cycles");
    AST_SEL_NEXT: assert property (
        irqByteOutputEnable && $past(irqByteOutputEnable)
        && byteSelect != $past(byteSelect)
        |-> byteSelect == $past(byteSelect) + SEL_STEP)
        else $error("byte select skipped a code");
    AST_RESTART: assert property (
        irqVectorStrobe && !busRequest
        |=> irqByteOutputEnable && byteSelect == FIRST_SEL)
        else $error("round did not restart at byte 0");

    ////////////////////////////////////////////////////////////////////////
    // sharing the bus with other accesses
    AST_GRANT_EXCL: assert property (
        busGrant |-> !irqByteOutputEnable && !busDataOe)
        else $error("bus driven while granted");
    AST_GRANT_WAIT: assert property (
        busRequest && !busGrant |-> ##[1:24] (busGrant || !busRequest))
        else $error("request not granted in time");
    AST_RESUME: assert property (
        busGrant && !busRequest
        |=> !busGrant ##1 (irqByteOutputEnable || busDataOe))
        else $error("polling did not resume");

    cover property (irqVectorStrobe);
    cover property ($rose(busGrant));
    cover property (busGrant && !busRequest);
endmodule

bind irq_poller irq_poller_chk #(.STEPS(STEPS)) chk (
    .core_clk(core_clk),
    .rst(rst),
    .busRequest(busRequest),
    .busGrant(busGrant),
    .byteSelect(byteSelect),
    .irqByteOutputEnable(irqByteOutputEnable),
    .irqVectorStrobe(irqVectorStrobe),
    .busDataOe(busDataOe)
);
`default_nettype wire

// ===== dv/irq_cpu_side.sv
// interrupt buffers and cpu vector flip-flops around the poller
`timescale 1ns/1ps
`default_nettype none

module irq_cpu_side
    import irq_poll_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [irq_poll_pkg::SEL_W-1:0] byteSelect,
    input wire logic irqByteOutputEnable,
    input wire logic irqVectorStrobe,
    input wire logic [irq_poll_pkg::BYTE_W-1:0] busDataOut,
    input wire logic [47:0] srcLines,
    output logic [irq_poll_pkg::BYTE_W-1:0] busDataIn,
    output logic [irq_poll_pkg::VEC_W-1:0] cpuVec0,
    output logic [irq_poll_pkg::VEC_W-1:0] cpuVec1
);
    import irq_poll_pkg::*;

    logic [7:0] lastByte;

    // selected buffer drives its byte; released bus shows the inverse
    always_comb
    begin
        busDataIn = irqByteOutputEnable
            ? srcLines[byteSelect*8 +: 8]
            : ~lastByte;
    end

    // record the bus byte every cycle and load the vector on the strobe
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            lastByte <= 8'h00;
            cpuVec0 <= 4'h0;
            cpuVec1 <= 4'h0;
        end
        else
        begin
            lastByte <= busDataIn;
            if (irqVectorStrobe)
            begin
                cpuVec0 <= busDataOut[3:0];
                cpuVec1 <= busDataOut[7:4];
            end
        end
    end
endmodule
`default_nettype wire

// ===== dv/test_tig_interrupt_poller.sv
// self-checking bench for the interrupt poller
`timescale 1ns/1ps
`default_nettype none

module test_tig_interrupt_poller;
    import irq_poll_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic busRequest = 1'b0;
    logic ctrlErrorIrq = 1'b0;
    logic ioErrorIrq = 1'b0;
    logic [1:0] interprocessorIrq = 2'h0;
    logic [1:0] softwareHalt = 2'h0;
    logic [47:0] srcLines = 48'h0;
    logic busGrant, irqByteOutputEnable, irqVectorStrobe, busDataOe;
    logic [2:0] byteSelect;
    logic [7:0] busDataIn, busDataOut;
    logic [3:0] cpuVec0, cpuVec1;
    logic [1:0] cpuHalt;
    int errTotal = 0;
    int testsRun = 0;
    int cycles = 0;
    logic [3:0] e0, e1;
    logic [1:0] eh;

    ////////////////////////////////////////////////////////////////////////
    // clock, design and far side
    always #5 core_clk = ~core_clk;

    irq_poller dut (.core_clk(core_clk), .rst(rst), .busRequest(busRequest),
        .busGrant(busGrant), .byteSelect(byteSelect),
        .irqByteOutputEnable(irqByteOutputEnable),
        .irqVectorStrobe(irqVectorStrobe), .busDataIn(busDataIn),
        .busDataOut(busDataOut), .busDataOe(busDataOe),
        .ctrlErrorIrq(ctrlErrorIrq), .ioErrorIrq(ioErrorIrq),
        .interprocessorIrq(interprocessorIrq), .softwareHalt(softwareHalt),
        .cpuHalt(cpuHalt));

    irq_cpu_side far (.core_clk(core_clk), .rst(rst), .byteSelect(byteSelect),
        .irqByteOutputEnable(irqByteOutputEnable),
        .irqVectorStrobe(irqVectorStrobe), .busDataOut(busDataOut),
        .srcLines(srcLines), .busDataIn(busDataIn), .cpuVec0(cpuVec0),
        .cpuVec1(cpuVec1));

    ////////////////////////////////////////////////////////////////////////
    // expectations, comparison and verdict
    function automatic logic [3:0] expNib(input logic [47:0] s,
                                          input logic ipi);
        logic [7:0] b4;
        b4 = s[39:32];
        expNib = {ipi, b4[5], (|s[27:0]) | b4[4],
            b4[0] | b4[1] | ctrlErrorIrq | ioErrorIrq};
    endfunction

    task automatic check(input string what, input logic [7:0] exp,
                         input logic [7:0] got);
        testsRun++;
        if (got !== exp)
        begin
            errTotal++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic printVerdict();
        $display("checks %0d mismatches %0d", testsRun, errTotal);
        if (errTotal == 0 && testsRun > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // cut a hang short
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            errTotal++;
            printVerdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // stimulus
    task automatic setInputs(input int i);
        case (i)
            0: srcLines = 48'h0;
            1: srcLines = 48'hFFFF_FFFF_FFFF;
            2: srcLines = 48'hFFC0_F000_0000;
            3: srcLines = 48'h0000_0800_0000;
            default: srcLines = (i % 2) ? 48'h1 << $urandom_range(47, 0)
                : {16'($urandom()), 32'($urandom())};
        endcase
        {softwareHalt, interprocessorIrq, ioErrorIrq, ctrlErrorIrq} =
            (i < 4) ? {6{i == 1}} : 6'($urandom());
    endtask

    task automatic waitFor(input logic strobe);
        int n;
        n = 0;
        do
        begin
            @(negedge core_clk);
            n++;
        end
        while ((strobe ? irqVectorStrobe : busGrant) !== 1'b1 && n < 100);
        if (n >= 100)
        begin
            errTotal++;
            printVerdict();
        end
    endtask

    initial
    begin
        void'($urandom(32'h012c));
        setInputs(0);
        repeat (2) @(negedge core_clk);
        rst = 1'b0;
        for (int i = 0; i < 40; i++)
        begin
            if (i % 3 == 2)
            begin
                repeat ($urandom_range(12, 1)) @(negedge core_clk);
                busRequest = 1'b1;
                waitFor(1'b0);
                repeat (3) @(negedge core_clk);
                busRequest = 1'b0;
            end
            waitFor(1'b1);
            e0 = expNib(srcLines, interprocessorIrq[0]);
            e1 = expNib(srcLines, interprocessorIrq[1]);
            eh = srcLines[35:34] | softwareHalt;
            check("vector", {e1, e0}, busDataOut);
            check("halt", {6'h0, eh}, {6'h0, cpuHalt});
            @(negedge core_clk);
            check("cpu0", {4'h0, e0}, {4'h0, cpuVec0});
            check("cpu1", {4'h0, e1}, {4'h0, cpuVec1});
            setInputs(i + 1);
        end
        printVerdict();
    end
endmodule
`default_nettype wire
